// ==== testbench/pwm_action_qualifier_tb_top.sv ====
`timescale 1ns/100ps
module pwm_action_qualifier_tb_top;
	import pwmaq_pkg::*;
	// ====================
	// Signals
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_we = 1'b0;
	logic reg_re = 1'b0;
	logic [15:0] reg_rdata;
	logic run = 1'b0;
	pwmaq_mode_type mode = MODE_UP;
	logic [15:0] prd = 16'h0005, cmp_first = 16'h0000, cmp_second = 16'h0000;
	logic tick, at_zero, at_prd, at_a, at_b, dir_up, out_a, out_b;
	wire logic [3:0] evt;
	logic [3:0] shd_r, act_r, ee_r;
	logic [15:0] ca_r, cb_r;
	logic [2:0] osa_r, osb_r;
	logic ea_r, eb_r;
	int mismatches = 0;
	int num_checks = 0;
	always #5 clk_sys = ~clk_sys;
	pwmaq_top DUT (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.timebase_tick(tick), .count_at_zero(at_zero), .count_at_period(at_prd),
		.count_at_first(at_a), .count_at_second(at_b), .count_dir_up(dir_up),
		.count_mode(mode), .period_value(prd), .compare_first_value(cmp_first),
		.compare_second_value(cmp_second), .pwm_out_first(out_a), .pwm_out_second(out_b),
		.evt_zero(evt[0]), .evt_period(evt[1]), .evt_first(evt[2]), .evt_second(evt[3]));
	pwmaq_tb_timebase tb_tbase (.clk_sys(clk_sys), .arst_n(arst_n), .run(run), .mode(mode),
		.prd(prd), .cmp_first(cmp_first), .cmp_second(cmp_second), .tick(tick),
		.at_zero(at_zero),
		.at_prd(at_prd), .at_a(at_a), .at_b(at_b), .dir_up(dir_up));
	// ====================
	// Reference model
	function automatic logic [1:0] fire(input logic m, input logic [15:0] c);
		case (mode)
			MODE_UP: fire = {1'b0, m && c <= prd};
			MODE_DOWN: fire = {c < prd ? m : at_prd, 1'b0};
			MODE_UPDOWN: fire = c < prd ? {m && !dir_up, m && dir_up} : {2{at_prd}};
			default: fire = 2'h0;
		endcase
	endfunction : fire
	function automatic logic nxt(input logic cur, input logic [15:0] ctl, input logic [5:0] f);
		logic o;
		logic [17:0] ord;
		logic [1:0] a;
		o = cur;
		case (mode)
			MODE_UP: ord = {3'h1, 3'h4, 3'h2, 3'h0, 3'h3, 3'h5};
			MODE_DOWN: ord = {3'h0, 3'h5, 3'h3, 3'h1, 3'h2, 3'h4};
			default: ord = dir_up ? {3'h4, 3'h2, 3'h0, 3'h5, 3'h3, 3'h1}
				: {3'h5, 3'h3, 3'h1, 3'h4, 3'h2, 3'h0};
		endcase
		for (int i = 0; i < 6; i++) begin
			a = ctl[2 * ord[3 * i +: 3] +: 2];
			if (f[ord[3 * i +: 3]] && a != 2'h0) o = a == 2'h1 ? 1'b0 : a == 2'h2 ? 1'b1 : ~cur;
		end
		return o;
	endfunction : nxt
	function automatic logic frc(input logic cur, input logic hw, input logic [1:0] cf,
		input logic [2:0] os);
		if (cf == CF_LOW) return 1'b0;
		if (cf == CF_HIGH) return 1'b1;
		if (os[2]) return os[1:0] == 2'h1 ? 1'b0 : os[1:0] == 2'h2 ? 1'b1 : ~cur;
		return hw;
	endfunction : frc
	always @(posedge clk_sys) begin : mdl
		logic [5:0] fh;
		if (!arst_n) begin
			{ca_r, cb_r, shd_r, act_r, osa_r, osb_r, ea_r, eb_r, ee_r} <= '0;
		end else begin
			chk(out_a, ea_r);
			chk(out_b, eb_r);
			chk(evt, ee_r);
			fh = (tick && mode != MODE_FROZEN) ? {fire(at_b, cmp_second), fire(at_a, cmp_first),
				at_prd, at_zero} : 6'h00;
			ea_r <= frc(ea_r, nxt(ea_r, ca_r, fh), act_r[1:0], osa_r);
			eb_r <= frc(eb_r, nxt(eb_r, cb_r, fh), act_r[3:2], osb_r);
			ee_r <= tick ? {at_b, at_a, at_prd, at_zero} : 4'h0;
			osa_r <= 3'h0;
			osb_r <= 3'h0;
			if (tick && at_zero) act_r <= shd_r;
			if (reg_we && reg_addr == ADDR_CTL_A) ca_r <= reg_wdata;
			if (reg_we && reg_addr == ADDR_CTL_B) cb_r <= reg_wdata;
			if (reg_we && reg_addr == ADDR_CONT) shd_r <= reg_wdata[3:0];
			if (reg_we && reg_addr == ADDR_ONCE) {osb_r, osa_r} <= reg_wdata[5:0];
		end
	end
	// ====================
	// Tasks and scenarios
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_we <= 1'b1;
		reg_re <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		reg_we <= 1'b0;
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_re <= 1'b0;
		@(posedge clk_sys);
		chk(reg_rdata, exp);
	endtask : rd
	task automatic idle(input int n);
		reg_we <= 1'b0;
		reg_re <= 1'b0;
		repeat (n) @(posedge clk_sys);
	endtask : idle
	task automatic t_regs;
		rd(ADDR_CTL_A, 16'h0000);
		rd(ADDR_CTL_B, 16'h0000);
		rd(ADDR_ONCE, 16'h0000);
		rd(ADDR_CONT, 16'h0000);
		rd(8'h00, 16'h0000);
		wr(ADDR_CTL_A, 16'hffff);
		wr(ADDR_CTL_B, 16'h0a5a);
		wr(ADDR_ONCE, 16'h003f);
		wr(ADDR_CONT, 16'hfff5);
		rd(ADDR_CTL_A, 16'h0fff);
		rd(ADDR_CTL_B, 16'h0a5a);
		rd(ADDR_ONCE, 16'h001b);
		rd(ADDR_CONT, 16'h0005);
		wr(ADDR_CONT, 16'h0000);
		idle(2);
	endtask : t_regs
	task automatic t_hw;
		pwmaq_mode_type ml[4] = '{MODE_UP, MODE_DOWN, MODE_UPDOWN, MODE_FROZEN};
		logic [15:0] cl[4] = '{16'h0000, 16'h0005, 16'h0007, 16'h0002};
		logic [15:0] kl[3] = '{16'h0e4b, 16'h0b1e, 16'h0619};
		for (int m = 0; m < 4; m++) begin
			for (int c = 0; c < 4; c++) begin
				for (int k = 0; k < 3; k++) begin
					run <= 1'b0;
					mode <= ml[m];
					cmp_first <= cl[c];
					cmp_second <= cl[(c + k) % 4];
					wr(ADDR_CTL_A, kl[k]);
					wr(ADDR_CTL_B, kl[(k + 1) % 3]);
					idle(1);
					run <= 1'b1;
					idle(14);
				end
			end
		end
	endtask : t_hw
	task automatic t_force;
		mode <= MODE_UP;
		wr(ADDR_ONCE, 16'h002e);
		wr(ADDR_ONCE, 16'h003f);
		wr(ADDR_ONCE, 16'h0035);
		wr(ADDR_CONT, 16'h0009);
		idle(10);
		rd(ADDR_CONT, 16'h0009);
		rd(ADDR_STATUS, 16'h0029);
		wr(ADDR_ONCE, 16'h003f);
		wr(ADDR_CONT, 16'h0006);
		idle(10);
		rd(ADDR_STATUS, 16'h0016);
		wr(ADDR_CONT, 16'h0000);
		idle(10);
	endtask : t_force
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (20000) @(posedge clk_sys);
		mismatches++;
		test_done;
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		t_regs;
		t_hw;
		t_force;
		test_done;
	end
endmodule : pwm_action_qualifier_tb_top

// ==== testbench/pwmaq_tb_timebase.sv ====
`timescale 1ns/100ps
module pwmaq_tb_timebase
	import pwmaq_pkg::*;
(
	// Clock, reset and set-up
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic run,
	input wire pwmaq_mode_type mode,
	input wire logic [15:0] prd,
	input wire logic [15:0] cmp_first,
	input wire logic [15:0] cmp_second,
	// Event strobes
	output logic tick,
	output logic at_zero,
	output logic at_prd,
	output logic at_a,
	output logic at_b,
	output logic dir_up
);
	// ====================
	// Counter
	logic [15:0] cnt_r;
	logic up_r;
	// Matches are scrambled while stopped; only the tick qualifies them
	assign tick = run;
	assign at_zero = (cnt_r == 16'h0000) ^ ~run;
	assign at_prd = (cnt_r == prd) ^ ~run;
	assign at_a = (cnt_r == cmp_first) ^ ~run;
	assign at_b = (cnt_r == cmp_second) ^ ~run;
	assign dir_up = up_r;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= 16'h0000;
			up_r <= 1'b1;
		end else if (!run) begin
			cnt_r <= (mode == MODE_DOWN) ? prd : 16'h0000;
			up_r <= (mode != MODE_DOWN);
		end else if (mode == MODE_UP) begin
			cnt_r <= (cnt_r == prd) ? 16'h0000 : cnt_r + 16'h0001;
		end else if (mode == MODE_DOWN) begin
			cnt_r <= (cnt_r == 16'h0000) ? prd : cnt_r - 16'h0001;
		end else if (mode == MODE_UPDOWN) begin
			cnt_r <= up_r ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
			if (up_r ? cnt_r == prd - 16'h0001 : cnt_r == 16'h0001) begin
				up_r <= ~up_r;
			end
		end
	end
endmodule : pwmaq_tb_timebase

// ==== verilog/pwmaq_pkg.sv ====
// Function
// - Per event: set, clear, toggle, or hold
// - Accept period, zero, compare A, compare B
// - Qualify events by current count direction
// - Toggle inverts the present output level
// - Hold keeps level, event still passed on
// - Separate actions per output, any combination
// - Reset selects hold for every event
// - Software force beats simultaneous hardware events
// - Continuous force shadowed; others unshadowed
// - Up-down rising priority order
// - Up-down falling priority order
// - Up-count mode priority order
// - Down-count mode priority order
// - Up-count mode: falling compare events never fire
// - Down-count mode: rising compare events never fire
// - Up-count: compare fires only if within period
// - Down-count: compare above period fires at period
// - Up-down: compare above period fires at period
// - Up-down: compare direction follows counting direction
// - Up-down: compare twice inside, once at ends
package pwmaq_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;
	localparam int CNT_W = 16;
	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_CTL_A = 6'h0b;
	localparam logic [5:0] IDX_CTL_B = 6'h0c;
	localparam logic [5:0] IDX_ONCE = 6'h0d;
	localparam logic [5:0] IDX_CONT = 6'h0e;
	localparam logic [5:0] IDX_STATUS = 6'h0f;
	localparam logic [7:0] ADDR_CTL_A = {IDX_CTL_A, 2'h0};
	localparam logic [7:0] ADDR_CTL_B = {IDX_CTL_B, 2'h0};
	localparam logic [7:0] ADDR_ONCE = {IDX_ONCE, 2'h0};
	localparam logic [7:0] ADDR_CONT = {IDX_CONT, 2'h0};
	localparam logic [7:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
	localparam logic [15:0] RST_REG = 16'h0000;
	localparam logic [15:0] MASK_CTL = 16'h0fff;
	localparam logic [15:0] MASK_ONCE_RD = 16'h001b;
	localparam logic [15:0] MASK_CONT = 16'h000f;
	// Event indices into the 2-bit action fields of a control register
	localparam int EV_ZERO = 0;
	localparam int EV_PRD = 1;
	localparam int EV_FIRST_RISE = 2;
	localparam int EV_FIRST_FALL = 3;
	localparam int EV_SECOND_RISE = 4;
	localparam int EV_SECOND_FALL = 5;
	// One-shot and continuous force fields
	localparam int FLD_OS_ACT_A = 0;
	localparam int FLD_OS_GO_A = 2;
	localparam int FLD_OS_ACT_B = 3;
	localparam int FLD_OS_GO_B = 5;
	localparam logic [1:0] CF_LOW = 2'h1;
	localparam logic [1:0] CF_HIGH = 2'h2;
	// Event order, lowest priority in bits [2:0], highest in [17:15]
	localparam logic [17:0] ORD_UP = {3'h1, 3'h4, 3'h2, 3'h0, 3'h5, 3'h3};
	localparam logic [17:0] ORD_DOWN = {3'h0, 3'h5, 3'h3, 3'h1, 3'h4, 3'h2};
	localparam logic [17:0] ORD_UD_RISE = {3'h4, 3'h2, 3'h0, 3'h5, 3'h3, 3'h1};
	localparam logic [17:0] ORD_UD_FALL = {3'h5, 3'h3, 3'h1, 3'h4, 3'h2, 3'h0};
	typedef enum logic [1:0] {
		ACT_NONE = 2'h0,
		ACT_CLEAR = 2'h1,
		ACT_SET = 2'h2,
		ACT_TOGGLE = 2'h3
	} pwmaq_act_type;
	typedef enum logic [1:0] {
		MODE_UP = 2'h0,
		MODE_DOWN = 2'h1,
		MODE_UPDOWN = 2'h3,
		MODE_FROZEN = 2'h2
	} pwmaq_mode_type;
endpackage : pwmaq_pkg

// ==== verilog/pwmaq_top.sv ====
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
module pwmaq_top
	import pwmaq_pkg::*;
#(
	parameter int CW = CNT_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [DATA_W-1:0] reg_rdata,
	// Time-base and compare events
	input wire logic timebase_tick,
	input wire logic count_at_zero,
	input wire logic count_at_period,
	input wire logic count_at_first,
	input wire logic count_at_second,
	input wire logic count_dir_up,
	input wire pwmaq_mode_type count_mode,
	input wire logic [CW-1:0] period_value,
	input wire logic [CW-1:0] compare_first_value,
	input wire logic [CW-1:0] compare_second_value,
	// PWM outputs
	output logic pwm_out_first,
	output logic pwm_out_second,
	// Events passed on downstream
	output logic evt_zero,
	output logic evt_period,
	output logic evt_first,
	output logic evt_second
);

	// ==========================================
	// Helpers
	function automatic logic [1:0] next_level_bit(input logic [1:0] act, input logic cur);
		logic [1:0] r;
		r = {1'b0, cur};
		case (act)
			ACT_CLEAR: r = 2'h0;
			ACT_SET: r = 2'h1;
			ACT_TOGGLE: r = {1'b0, ~cur};
			default: r = {1'b0, cur};
		endcase
		return r;
	endfunction : next_level_bit

	function automatic logic cmp_up(input logic match, input logic [CW-1:0] cmp,
			input logic [CW-1:0] prd, input logic prd_ev, input pwmaq_mode_type mode,
			input logic dir);
		logic r;
		r = 1'b0;
		case (mode)
			MODE_UP: r = match && (cmp <= prd);
			MODE_UPDOWN: r = (cmp >= prd) ? prd_ev : (match && dir);
			default: r = 1'b0;
		endcase
		return r;
	endfunction : cmp_up

	function automatic logic cmp_dn(input logic match, input logic [CW-1:0] cmp,
			input logic [CW-1:0] prd, input logic prd_ev, input pwmaq_mode_type mode,
			input logic dir);
		logic r;
		r = 1'b0;
		case (mode)
			MODE_DOWN: r = (cmp < prd) ? match : prd_ev;
			MODE_UPDOWN: r = (cmp >= prd) ? prd_ev : (match && !dir);
			default: r = 1'b0;
		endcase
		return r;
	endfunction : cmp_dn

	function automatic logic [1:0] resolve(input logic [15:0] ctl, input logic [5:0] ev,
			input pwmaq_mode_type mode, input logic dir);
		logic [17:0] ord;
		logic [2:0] k;
		logic [1:0] a;
		logic [1:0] r;
		r = ACT_NONE;
		case (mode)
			MODE_UP: ord = ORD_UP;
			MODE_DOWN: ord = ORD_DOWN;
			MODE_UPDOWN: ord = dir ? ORD_UD_RISE : ORD_UD_FALL;
			default: ord = ORD_UP;
		endcase
		for (int i = 0; i < 6; i++) begin
			k = ord[3*i +: 3];
			a = ctl[2*k +: 2];
			if (ev[k] && a != ACT_NONE) begin
				r = a;
			end
		end
		return r;
	endfunction : resolve

	// ==========================================
	// Event qualification
	logic run;
	wire logic [5:0] ev;
	assign run = timebase_tick && (count_mode != MODE_FROZEN);
	assign ev[EV_ZERO] = run && count_at_zero;
	assign ev[EV_PRD] = run && count_at_period;
	assign ev[EV_FIRST_RISE] = run && cmp_up(count_at_first, compare_first_value, period_value,
		count_at_period, count_mode, count_dir_up);
	assign ev[EV_FIRST_FALL] = run && cmp_dn(count_at_first, compare_first_value, period_value,
		count_at_period, count_mode, count_dir_up);
	assign ev[EV_SECOND_RISE] = run && cmp_up(count_at_second, compare_second_value,
		period_value, count_at_period, count_mode, count_dir_up);
	assign ev[EV_SECOND_FALL] = run && cmp_dn(count_at_second, compare_second_value,
		period_value, count_at_period, count_mode, count_dir_up);

	// ==========================================
	// Registers
	logic [15:0] ctl_a_r;
	logic [15:0] ctl_b_r;
	logic [15:0] once_r;
	logic [1:0] os_go_r;
	logic [3:0] cont_sh_r;
	logic [3:0] cont_act_r;
	logic [1:0] out_r;
	logic [15:0] rdata_r;
	logic wr_once;

	assign wr_once = reg_we && (reg_addr == ADDR_ONCE);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ctl_a_r <= RST_REG;
			ctl_b_r <= RST_REG;
			once_r <= RST_REG;
			cont_sh_r <= 4'h0;
		end else if (reg_we) begin
			case (reg_addr)
				ADDR_CTL_A: ctl_a_r <= reg_wdata & MASK_CTL;
				ADDR_CTL_B: ctl_b_r <= reg_wdata & MASK_CTL;
				ADDR_ONCE: once_r <= reg_wdata & MASK_ONCE_RD;
				ADDR_CONT: cont_sh_r <= reg_wdata[3:0];
				default: ;
			endcase
		end
	end

	// One-shot force pulses last exactly the cycle after the write
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			os_go_r <= 2'h0;
		end else begin
			os_go_r <= wr_once ? {reg_wdata[FLD_OS_GO_B], reg_wdata[FLD_OS_GO_A]} : 2'h0;
		end
	end

	// Active continuous force loads from shadow at counter zero
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cont_act_r <= 4'h0;
		end else if (timebase_tick && count_at_zero) begin
			cont_act_r <= cont_sh_r;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= 16'h0000;
		end else if (reg_re) begin
			case (reg_addr)
				ADDR_CTL_A: rdata_r <= ctl_a_r;
				ADDR_CTL_B: rdata_r <= ctl_b_r;
				ADDR_ONCE: rdata_r <= once_r;
				ADDR_CONT: rdata_r <= {12'h000, cont_sh_r};
				ADDR_STATUS: rdata_r <= {10'h000, out_r, cont_act_r};
				default: rdata_r <= 16'h0000;
			endcase
		end else begin
			rdata_r <= 16'h0000;
		end
	end
	assign reg_rdata = rdata_r;

	// ==========================================
	// Output channels
	logic [1:0] hw_act [2];
	logic [1:0] os_act [2];
	assign os_act[0] = once_r[FLD_OS_ACT_A +: 2];
	assign os_act[1] = once_r[FLD_OS_ACT_B +: 2];

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			logic [1:0] cf;
			logic [1:0] nl;
			assign cf = cont_act_r[2*ch +: 2];
			assign hw_act[ch] = resolve(ch == 0 ? ctl_a_r : ctl_b_r, ev, count_mode,
				count_dir_up);
			assign nl = os_go_r[ch] ? next_level_bit(os_act[ch], out_r[ch]) :
				next_level_bit(hw_act[ch], out_r[ch]);
			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					out_r[ch] <= 1'b0;
				end else if (cf == CF_LOW) begin
					out_r[ch] <= 1'b0;
				end else if (cf == CF_HIGH) begin
					out_r[ch] <= 1'b1;
				end else begin
					out_r[ch] <= nl[0];
				end
			end
		end
	endgenerate
	assign pwm_out_first = out_r[0];
	assign pwm_out_second = out_r[1];

	// ==========================================
	// Event pass-on
	logic [3:0] evt_r;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			evt_r <= 4'h0;
		end else begin
			evt_r <= {4{timebase_tick}} & {count_at_second, count_at_first, count_at_period,
				count_at_zero};
		end
	end
	assign evt_zero = evt_r[0];
	assign evt_period = evt_r[1];
	assign evt_first = evt_r[2];
	assign evt_second = evt_r[3];

	// ==========================================
	// Assertions
	logic cf_idle_a;
	assign cf_idle_a = cont_act_r[1:0] != CF_LOW && cont_act_r[1:0] != CF_HIGH;
	logic cf_idle_b;
	assign cf_idle_b = cont_act_r[3:2] != CF_LOW && cont_act_r[3:2] != CF_HIGH;

	property p_hold_idle;
		@(posedge clk_sys) disable iff (!arst_n)
		ctl_a_r == 16'h0000 && !os_go_r[0] && cf_idle_a |=> $stable(out_r[0]);
	endproperty
	a_hold_idle: assert property (p_hold_idle) else $error("Output moved with all idle");

	property p_toggle;
		@(posedge clk_sys) disable iff (!arst_n)
		ev == 6'h01 && ctl_a_r[1:0] == ACT_TOGGLE && !os_go_r[0] && cf_idle_a
		|=> out_r[0] == !$past(out_r[0]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("Toggle did not invert");

	property p_force_wins;
		@(posedge clk_sys) disable iff (!arst_n)
		os_go_r[0] && once_r[1:0] == ACT_SET && cf_idle_a |=> out_r[0];
	endproperty
	a_force_wins: assert property (p_force_wins) else $error("Force set lost");

	property p_up_no_down;
		@(posedge clk_sys) disable iff (!arst_n)
		count_mode == MODE_UP |-> !ev[EV_FIRST_FALL] && !ev[EV_SECOND_FALL];
	endproperty
	a_up_no_down: assert property (p_up_no_down) else $error("Down event in up mode");

	property p_down_no_up;
		@(posedge clk_sys) disable iff (!arst_n)
		count_mode == MODE_DOWN |-> !ev[EV_FIRST_RISE] && !ev[EV_SECOND_RISE];
	endproperty
	a_down_no_up: assert property (p_down_no_up) else $error("Up event in down mode");

	property p_up_beyond;
		@(posedge clk_sys) disable iff (!arst_n)
		count_mode == MODE_UP && compare_first_value > period_value |-> !ev[EV_FIRST_RISE];
	endproperty
	a_up_beyond: assert property (p_up_beyond) else $error("Compare beyond period fired");

	property p_down_at_prd;
		@(posedge clk_sys) disable iff (!arst_n)
		count_mode == MODE_DOWN && timebase_tick && count_at_period
		&& compare_first_value >= period_value |-> ev[EV_FIRST_FALL];
	endproperty
	a_down_at_prd: assert property (p_down_at_prd) else $error("Down compare missed");

	property p_ud_at_prd;
		@(posedge clk_sys) disable iff (!arst_n)
		count_mode == MODE_UPDOWN && timebase_tick && count_at_period
		&& compare_first_value >= period_value |-> ev[EV_FIRST_RISE] && ev[EV_FIRST_FALL];
	endproperty
	a_ud_at_prd: assert property (p_ud_at_prd) else $error("Up-down period compare");

	property p_shadow;
		@(posedge clk_sys) disable iff (!arst_n)
		!(timebase_tick && count_at_zero) |=> $stable(cont_act_r);
	endproperty
	a_shadow: assert property (p_shadow) else $error("Active force changed early");

	property p_pass_on;
		@(posedge clk_sys) disable iff (!arst_n)
		timebase_tick && count_at_zero |=> evt_zero;
	endproperty
	a_pass_on: assert property (p_pass_on) else $error("Zero event not passed on");

	property p_up_prio;
		@(posedge clk_sys) disable iff (!arst_n)
		count_mode == MODE_UP && ev[EV_PRD] && ev[EV_FIRST_RISE] && ctl_a_r[3:2] == ACT_SET
		&& ctl_a_r[5:4] == ACT_CLEAR && !os_go_r[0] && cf_idle_a |=> out_r[0];
	endproperty
	a_up_prio: assert property (p_up_prio) else $error("Period lost to compare");

	property p_force_clear;
		@(posedge clk_sys) disable iff (!arst_n)
		os_go_r[0] && once_r[1:0] == ACT_CLEAR && cf_idle_a |=> !out_r[0];
	endproperty
	a_force_clear: assert property (p_force_clear) else $error("Force clear lost");

	property p_cont_low;
		@(posedge clk_sys) disable iff (!arst_n)
		cont_act_r[1:0] == CF_LOW |=> !out_r[0];
	endproperty
	a_cont_low: assert property (p_cont_low) else $error("Continuous low lost");

	property p_cont_high;
		@(posedge clk_sys) disable iff (!arst_n)
		cont_act_r[3:2] == CF_HIGH |=> out_r[1];
	endproperty
	a_cont_high: assert property (p_cont_high) else $error("Continuous high lost");

	property p_hold_idle_b;
		@(posedge clk_sys) disable iff (!arst_n)
		ctl_b_r == 16'h0000 && !os_go_r[1] && cf_idle_b |=> $stable(out_r[1]);
	endproperty
	a_hold_idle_b: assert property (p_hold_idle_b) else $error("Output B moved idle");

	property p_frozen_quiet;
		@(posedge clk_sys) disable iff (!arst_n)
		count_mode == MODE_FROZEN |-> ev == 6'h00;
	endproperty
	a_frozen_quiet: assert property (p_frozen_quiet) else $error("Event while frozen");

	property p_no_tick;
		@(posedge clk_sys) disable iff (!arst_n)
		!timebase_tick |=> !evt_zero && !evt_period && !evt_first && !evt_second;
	endproperty
	a_no_tick: assert property (p_no_tick) else $error("Event passed without tick");

	property p_pass_period;
		@(posedge clk_sys) disable iff (!arst_n)
		timebase_tick && count_at_period |=> evt_period;
	endproperty
	a_pass_period: assert property (p_pass_period) else $error("Period not passed on");

	property p_pass_first;
		@(posedge clk_sys) disable iff (!arst_n)
		timebase_tick && count_at_first |=> evt_first;
	endproperty
	a_pass_first: assert property (p_pass_first) else $error("Compare A not passed on");

	property p_pass_second;
		@(posedge clk_sys) disable iff (!arst_n)
		timebase_tick && count_at_second |=> evt_second;
	endproperty
	a_pass_second: assert property (p_pass_second) else $error("Compare B not passed");

	property p_ud_rise_only;
		@(posedge clk_sys) disable iff (!arst_n)
		count_mode == MODE_UPDOWN && compare_first_value < period_value && !count_dir_up
		|-> !ev[EV_FIRST_RISE];
	endproperty
	a_ud_rise_only: assert property (p_ud_rise_only) else $error("Rising event on way down");

	property p_ud_fall_only;
		@(posedge clk_sys) disable iff (!arst_n)
		count_mode == MODE_UPDOWN && compare_first_value < period_value && count_dir_up
		|-> !ev[EV_FIRST_FALL];
	endproperty
	a_ud_fall_only: assert property (p_ud_fall_only) else $error("Falling event on way up");

	property p_up_fires;
		@(posedge clk_sys) disable iff (!arst_n)
		count_mode == MODE_UP && timebase_tick && count_at_first
		&& compare_first_value <= period_value |-> ev[EV_FIRST_RISE];
	endproperty
	a_up_fires: assert property (p_up_fires) else $error("Up compare missed");

	property p_ud_rise_prio;
		@(posedge clk_sys) disable iff (!arst_n)
		count_mode == MODE_UPDOWN && count_dir_up && ev == 6'h05 && ctl_a_r[1:0] == ACT_SET
		&& ctl_a_r[5:4] == ACT_CLEAR && !os_go_r[0] && cf_idle_a |=> !out_r[0];
	endproperty
	a_ud_rise_prio: assert property (p_ud_rise_prio) else $error("Zero beat compare");

endmodule : pwmaq_top
